// ==== ifau_pkg.sv ====
// package of constants and types for the indirect file address unit
package ifau_pkg;
	// ****************************************
	// register offsets and fields
	// ****************************************
	localparam logic [6:0]  OFS_INDIRECT_DATA_PORT = 7'h00;
	localparam logic [6:0]  OFS_STATUS_WORD        = 7'h03;
	localparam logic [6:0]  OFS_POINTER_REGISTER   = 7'h04;
	localparam int          POS_INDIRECT_BANK_BIT  = 7;
	localparam int          POS_DIRECT_BANK_HIGH   = 6;
	localparam int          POS_DIRECT_BANK_LOW    = 5;
	localparam logic [7:0]  RST_STATUS_WORD        = 8'h00;
	localparam logic [7:0]  RST_POINTER_REGISTER   = 8'h00;
	// general purpose area of each bank
	localparam logic [6:0]  OFS_GP_FIRST           = 7'h0c;
	localparam logic [6:0]  OFS_GP_LAST            = 7'h7f;
	// ****************************************
	// bus register map, word aligned
	// ****************************************
	localparam logic [3:0]  WB_CTRL                = 4'h0;
	localparam logic [3:0]  WB_ADDR                = 4'h4;
	localparam logic [3:0]  WB_DATA                = 4'h8;
	localparam logic [3:0]  WB_INFO                = 4'hc;
	localparam logic [1:0]  ST_IDLE                = 2'b00;

	typedef enum logic [1:0] {
		IFAU_IDLE = 2'b00,
		IFAU_ACK  = 2'b01
	} ifau_state_type;

	typedef struct packed {
		ifau_state_type state;
		logic [7:0]     status;
		logic [7:0]     pointer;
		logic           small_map;
		logic [6:0]     file_addr;
		logic           indirect_sel;
		logic [8:0]     last_addr;
		logic           last_alias;
		logic [31:0]    rdata;
	} ifau_regs_type;
endpackage

// ==== ifau_top.sv ====
// indirect file address unit with classic wishbone slave
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: unimplemented locations read back as zero
// RULE2: small map folds bank 1 gp onto bank 0
// RULE3: port operand uses the pointer address instead
// RULE4: pointer zero through port reads zero
// RULE5: writing port through itself changes nothing
// RULE6: indirect address is bank bit plus pointer
// RULE7: bank bit picks banks 2-3, else 0-1
// RULE8: two bank bits pick one of four
// RULE9: direct address is bank bits plus field
// RULE10: pointer, port and status common to banks
module ifau_top
	import ifau_pkg::*;
#(
	parameter int GP_BANKS = 4
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o
);
	// ****************************************
	// state and storage
	// ****************************************
	ifau_regs_type r_reg;
	ifau_regs_type r_next;
	logic [7:0]    mem_reg [0:511];
	logic [3:0]    bank_present;
	logic [8:0]    raw_addr;
	logic [8:0]    eff_addr;
	logic          use_indirect;
	logic          self_ref;
	logic          alias_hit;
	logic          is_status;
	logic          is_pointer;
	logic          is_port;
	logic          is_special;
	logic          mem_impl;
	logic [7:0]    file_rdata;
	logic          file_we;
	logic [7:0]    file_wdata;
	logic          req;
	logic          wr_req;
	logic          hit_ctrl;
	logic          hit_addr;
	logic          hit_data;
	logic          hit_info;
	logic [31:0]   bus_rdata;

	// ****************************************
	// bus request decode
	// ****************************************
	// only the low byte lane carries register write data
	assign req      = cyc_i & stb_i & (r_reg.state == IFAU_IDLE);
	assign wr_req   = req & we_i & sel_i[0];
	assign hit_ctrl = (adr_i == WB_CTRL);
	assign hit_addr = (adr_i == WB_ADDR);
	assign hit_data = (adr_i == WB_DATA);
	assign hit_info = (adr_i == WB_INFO);

	// ****************************************
	// banks that hold general purpose memory
	// ****************************************
	// upper banks vanish on the small map; bank 1 folds instead
	generate
		for (genvar b = 0; b < 4; b++)
		begin : g_bank
			assign bank_present[b] = (b < GP_BANKS) && !(r_reg.small_map && (b >= 2));
		end
	endgenerate

	// ****************************************
	// address generation
	// ****************************************
	always_comb
	begin
		use_indirect = (r_reg.file_addr == OFS_INDIRECT_DATA_PORT) || r_reg.indirect_sel; // RULE3
		if (use_indirect)
			raw_addr = {r_reg.status[POS_INDIRECT_BANK_BIT], r_reg.pointer}; // RULE6 RULE7
		else
			raw_addr = {r_reg.status[POS_DIRECT_BANK_HIGH], // RULE8 RULE9
				r_reg.status[POS_DIRECT_BANK_LOW], r_reg.file_addr};
		// port at offset 00 of any bank points back at itself
		self_ref = use_indirect && (r_reg.pointer[6:0] == OFS_INDIRECT_DATA_PORT); // RULE4 RULE5
	end

	// ****************************************
	// bank 1 alias on the small map
	// ****************************************
	always_comb
	begin
		alias_hit = r_reg.small_map && (raw_addr[8:7] == 2'b01) &&
			(raw_addr[6:0] >= OFS_GP_FIRST); // RULE2
		if (alias_hit)
			eff_addr = {2'b00, raw_addr[6:0]};
		else
			eff_addr = raw_addr;
	end

	// ****************************************
	// location decode
	// ****************************************
	// core registers sit at one offset in every bank
	assign is_status  = (eff_addr[6:0] == OFS_STATUS_WORD); // RULE10
	assign is_pointer = (eff_addr[6:0] == OFS_POINTER_REGISTER); // RULE10
	assign is_port    = (eff_addr[6:0] == OFS_INDIRECT_DATA_PORT); // RULE10
	assign is_special = is_status | is_pointer | is_port;
	assign mem_impl   = (eff_addr[6:0] >= OFS_GP_FIRST) && bank_present[eff_addr[8:7]];

	// ****************************************
	// file read data
	// ****************************************
	always_comb
	begin
		if (self_ref)
			file_rdata = 8'h00; // RULE4
		else if (is_status)
			file_rdata = r_reg.status;
		else if (is_pointer)
			file_rdata = r_reg.pointer;
		else if (mem_impl)
			file_rdata = mem_reg[eff_addr];
		else
			file_rdata = 8'h00; // RULE1
	end

	// ****************************************
	// bus read data
	// ****************************************
	always_comb
	begin
		bus_rdata = 32'h0000_0000;
		if (hit_ctrl)
			bus_rdata = {30'h0, r_reg.indirect_sel, r_reg.small_map};
		else if (hit_addr)
			bus_rdata = {25'h0, r_reg.file_addr};
		else if (hit_data)
			bus_rdata = {24'h0, file_rdata};
		else if (hit_info)
			bus_rdata = {22'h0, r_reg.last_alias, r_reg.last_addr};
	end

	// ****************************************
	// register update
	// ****************************************
	// a write lands on the edge that takes the request; ack follows
	always_comb
	begin
		r_next = r_reg;
		file_we = 1'b0;
		file_wdata = dat_i[7:0];
		unique case (r_reg.state)
			IFAU_IDLE:
			begin
				if (req)
				begin
					r_next.state = IFAU_ACK;
					r_next.rdata = bus_rdata;
					unique case (adr_i)
						WB_CTRL:
						begin
							if (wr_req)
							begin
								r_next.small_map = dat_i[0];
								r_next.indirect_sel = dat_i[1];
							end
						end
						WB_ADDR:
						begin
							if (wr_req)
								r_next.file_addr = dat_i[6:0];
						end
						WB_DATA:
						begin
							r_next.last_addr = eff_addr;
							r_next.last_alias = alias_hit;
							// self write is a no-op on contents
							if (wr_req && !self_ref) // RULE5
							begin
								if (is_status)
									r_next.status = dat_i[7:0]; // RULE10
								else if (is_pointer)
									r_next.pointer = dat_i[7:0];
								else if (mem_impl && !is_special)
									file_we = 1'b1;
							end
						end
						default:
						begin
							// info and unmapped offsets only read
							file_we = 1'b0;
						end
					endcase
				end
			end
			IFAU_ACK:
				r_next.state = IFAU_IDLE;
			default:
				r_next.state = IFAU_IDLE;
		endcase
	end

	// ****************************************
	// state registers
	// ****************************************

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r_reg.state <= IFAU_IDLE;
			r_reg.status <= RST_STATUS_WORD;
			r_reg.pointer <= RST_POINTER_REGISTER;
			r_reg.small_map <= 1'b0;
			r_reg.file_addr <= 7'h00;
			r_reg.indirect_sel <= 1'b0;
			r_reg.last_addr <= 9'h000;
			r_reg.last_alias <= 1'b0;
			r_reg.rdata <= 32'h0000_0000;
		end
		else
			r_reg <= r_next;
	end

	// ****************************************
	// general purpose memory
	// ****************************************
	// memory has no reset; software clears it
	always_ff @(posedge clk_i)
	begin
		if (file_we)
			mem_reg[eff_addr] <= file_wdata;
	end

	// ****************************************
	// outputs
	// ****************************************
	// ack straight from state keeps it to exactly one cycle
	assign ack_o = (r_reg.state == IFAU_ACK);
	assign dat_o = r_reg.rdata;
endmodule

// ==== ifau_properties.sv ====
// bus checker for ifau_top
`timescale 1ns/10ps
module ifau_properties
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic        ack_o,
	input wire logic [3:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire rd = ack_o && !we_i;
	ack_next_a: assert property ($rose(stb_i) |=> ack_o) else $error("no ack");
	ack_once_a: assert property (ack_o |=> !ack_o) else $error("long ack");
	ack_cause_a: assert property (ack_o |-> $past(stb_i)) else $error("stray ack");
	ack_idle_a: assert property (!stb_i |=> !ack_o) else $error("idle ack");
	ack_held_a: assert property (ack_o |-> $stable(adr_i)) else $error("moved");
	gap_zero_a: assert property (rd && adr_i[1:0] != 2'h0 |-> !dat_o) else $error("gap");
	data_byte_a: assert property (rd && adr_i == 4'h8 |-> !dat_o[31:8]) else $error("wide");
	info_span_a: assert property (rd && adr_i == 4'hc |-> !dat_o[31:10]) else $error("info");
	cover property (ack_o && we_i);
	cover property (rd && adr_i == 4'h8);
	cover property (rd && adr_i == 4'hc);
	cover property (ack_o && we_i && !sel_i[0]);
endmodule
bind ifau_top ifau_properties u_ifau_properties (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .sel_i, .dat_i, .dat_o, .ack_o);

// ==== ifau_core.sv ====
// bus master standing in for the core execution logic
`timescale 1ns/10ps
module ifau_core
(
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o = 1'b0,
	output logic             we_o  = 1'b0,
	output logic [3:0]       adr_o = 4'h0,
	output logic [3:0]       sel_o = 4'h0,
	output logic [31:0]      dat_o = 32'h0
);
	// request held until ack seen on a rising edge, then dropped
	task xfer(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		{cyc_o, we_o, adr_o, sel_o, dat_o} <= {1'b1, w, a, s, 24'h0, d};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		r = dat_i;
		cyc_o <= 1'b0;
	endtask
endmodule

// ==== ifau_top_tb.sv ====
// bench for ifau_top
`timescale 1ns/10ps
module ifau_top_tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc, we_i, ack_o;
	logic [3:0]  adr_i;
	logic [3:0]  sel_i;
	logic [3:0]  sel = 4'hf;
	logic [31:0] dat_i, dat_o, got;
	int          num_errors = 0, compares = 0;
	ifau_top u_ifau_top (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(cyc), .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o);
	ifau_core u_ifau_core (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
	initial forever #25 clk_i = ~clk_i;
	// scenarios need about 150 cycles; this 2000-cycle limit is ample
	initial #100000 print_verdict(1'b1);
	task chk(input logic [31:0] s, e);
		compares++;
		num_errors += int'(s !== e);
		if (s !== e)
			$display("unexpected at %0t: %h vs %h", $time, s, e);
	endtask
	// reads compare with v, writes send its low byte
	task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		u_ifau_core.xfer(w, a, sel, v[7:0], got);
		if (!w)
			chk(got, v);
	endtask
	task setf(input logic [6:0] f, input logic [7:0] v);
		bus(1'b1, 4'h4, {25'h0, f});
		bus(1'b1, 4'h8, {24'h0, v});
	endtask
	task t_indirect;
		setf(7'h03, 8'h60);
		setf(7'h20, 8'h5a);
		bus(1'b0, 4'hc, 32'h1a0);
		setf(7'h03, 8'h80);
		setf(7'h04, 8'ha0);
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b0, 4'h8, 32'h5a);
		setf(7'h04, 8'h00);
		setf(7'h00, 8'h33);
		bus(1'b0, 4'h8, 32'h0);
		bus(1'b1, 4'h4, 32'h3);
		bus(1'b0, 4'h8, 32'h80);
		bus(1'b1, 4'h4, 32'h4);
		bus(1'b0, 4'h8, 32'h0);
	endtask
	task t_map;
		bus(1'b0, 4'h2, 32'h0);
		bus(1'b1, 4'h0, 32'h1);
		setf(7'h03, 8'h20);
		setf(7'h30, 8'h77);
		bus(1'b0, 4'hc, 32'h230);
		setf(7'h03, 8'h00);
		bus(1'b1, 4'h4, 32'h30);
		bus(1'b0, 4'h8, 32'h77);
	endtask
	// unimplemented file spots, absent banks, masked byte lane
	task t_refuse;
		bus(1'b1, 4'h4, 32'h5);
		bus(1'b0, 4'h8, 32'h0);
		setf(7'h40, 8'h11);
		sel = 4'he;
		bus(1'b1, 4'h8, 32'h99);
		sel = 4'hf;
		bus(1'b0, 4'h8, 32'h11);
		setf(7'h03, 8'h40);
		bus(1'b1, 4'h4, 32'h40);
		bus(1'b1, 4'h8, 32'h55);
		bus(1'b0, 4'h8, 32'h0);
		setf(7'h03, 8'h00);
	endtask
	// reset in mid-run clears mode, field and pointer
	task t_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		bus(1'b1, 4'h4, 32'h3);
		bus(1'b0, 4'h8, 32'h0);
	endtask
	task print_verdict(input logic late);
		num_errors += int'(late);
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_indirect;
		t_map;
		t_refuse;
		t_reset;
		print_verdict(1'b0);
	end
endmodule
